// ### hw/dcoff_cal_top.sv
// Serial-programmed dc-offset calibration control for receive and cross-polarization chains
`timescale 1ns/10ps
`include "dcoff_params.svh"

module dcoff_cal_top (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RSTN,
    input  wire logic        I_SPI_CLK,
    input  wire logic        I_SPI_DATA,
    input  wire logic        I_SPI_LE,
    input  wire logic        I_RX_I_OFS_POS,
    input  wire logic        I_RX_Q_OFS_POS,
    input  wire logic        I_XPOL_I_OFS_POS,
    input  wire logic        I_XPOL_Q_OFS_POS,
    output logic [7:0]       O_RX_I_DAC,
    output logic [7:0]       O_RX_Q_DAC,
    output logic [7:0]       O_XPOL_I_DAC,
    output logic [7:0]       O_XPOL_Q_DAC,
    output logic [1:0]       O_RX_FULL_SCALE,
    output logic [1:0]       O_XPOL_FULL_SCALE,
    output logic [2:0]       O_RX_STEP_MULT,
    output logic [2:0]       O_XPOL_STEP_MULT,
    output logic             O_RX_AUTOCAL_GO,
    output logic             O_XPOL_AUTOCAL_GO
);

    dcoff_pkg::top_regs_t  r;
    dcoff_pkg::top_regs_t  r_nxt;
    logic [1:0]            eng_busy;
    logic [1:0]            eng_done;
    logic [1:0]            eng_start;
    logic [1:0]            i_pos;
    logic [1:0]            q_pos;
    logic [2:0]            ratio [2];
    dcoff_pkg::corr_pair_t eng_code [2];
    logic                  spi_rise;
    logic                  le_rise;
    logic [31:0]           word;
    logic [2:0]            addr;

    assign spi_rise = I_SPI_CLK && !r.spi_clk_d;
    assign le_rise  = I_SPI_LE && !r.spi_le_d;
    assign word     = r.shift;
    assign addr     = word[`SER_ADDR_HI:`SER_ADDR_LO];

    assign i_pos    = {I_XPOL_I_OFS_POS, I_RX_I_OFS_POS};
    assign q_pos    = {I_XPOL_Q_OFS_POS, I_RX_Q_OFS_POS};
    assign ratio[0] = r.rx.ratio;
    assign ratio[1] = r.xpol.ratio;

    // Start pulse for each engine on the cycle the go bit is written to one
    assign eng_start[0] = le_rise && addr == `REG_CAL_CONTROL && word[`RX_GO_BIT];
    assign eng_start[1] = le_rise && addr == `REG_CAL_CONTROL && word[`XPOL_GO_BIT];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_chain
            dcoff_cal_engine u_engine (
                .i_clk   (I_CORE_CLK),
                .i_rstn  (I_RSTN),
                .i_start (eng_start[g]),
                .i_ratio (ratio[g]),
                .i_i_pos (i_pos[g]),
                .i_q_pos (q_pos[g]),
                .o_busy  (eng_busy[g]),
                .o_done  (eng_done[g]),
                .o_code  (eng_code[g])
            );
        end
    endgenerate

    always_comb begin
        r_nxt = r;
        r_nxt.spi_clk_d = I_SPI_CLK;
        r_nxt.spi_le_d  = I_SPI_LE;
        // Serial word shifts in least significant bit first
        if (spi_rise) begin
            r_nxt.shift = {I_SPI_DATA, r.shift[31:1]};
        end
        // Hardware clears the go bit when its engine finishes
        if (eng_done[0]) begin
            r_nxt.rx.go = 1'b0;
        end
        if (eng_done[1]) begin
            r_nxt.xpol.go = 1'b0;
        end
        if (le_rise && addr == `REG_CAL_CONTROL) begin
            r_nxt.rx.ratio        = word[`RX_RATIO_HI:`RX_RATIO_LO];
            r_nxt.xpol.ratio      = word[`XPOL_RATIO_HI:`XPOL_RATIO_LO];
            r_nxt.rx.full_scale   = word[`RX_FS_HI:`RX_FS_LO];
            r_nxt.xpol.full_scale = word[`XPOL_FS_HI:`XPOL_FS_LO];
            // A new start wins over a clear in the same cycle
            if (word[`RX_GO_BIT]) begin
                r_nxt.rx.go = 1'b1;
            end
            if (word[`XPOL_GO_BIT]) begin
                r_nxt.xpol.go = 1'b1;
            end
        end
        if (le_rise && addr == `REG_CAL_VALUES) begin
            r_nxt.src_sel        = word[`SRC_SEL_BIT];
            r_nxt.manual.i_code  = word[`I_CODE_HI:`I_CODE_LO];
            r_nxt.manual.q_code  = word[`Q_CODE_HI:`Q_CODE_LO];
        end
        // Source select picks engine result or host-written codes
        r_nxt.rx_dac   = r.src_sel ? eng_code[0] : r.manual;
        r_nxt.xpol_dac = r.src_sel ? eng_code[1] : r.manual;
        // Step multiple of a 10 mV / 256 unit: code 0..3 means 10..40 mV
        r_nxt.rx_step   = {1'b0, r.rx.full_scale} + 3'h1;
        r_nxt.xpol_step = {1'b0, r.xpol.full_scale} + 3'h1;
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
            r.shift      <= 32'h0000_0000;
            r.spi_clk_d  <= 1'b0;
            r.spi_le_d   <= 1'b0;
            r.rx         <= '{ratio: `RATIO_RESET, full_scale: `FS_RESET, go: 1'b0};
            r.xpol       <= '{ratio: `RATIO_RESET, full_scale: `FS_RESET, go: 1'b0};
            r.src_sel    <= `SRC_SEL_RESET;
            r.manual     <= '{i_code: `HALF_SCALE, q_code: `HALF_SCALE};
            r.rx_dac     <= '{i_code: `HALF_SCALE, q_code: `HALF_SCALE};
            r.xpol_dac   <= '{i_code: `HALF_SCALE, q_code: `HALF_SCALE};
            r.rx_step    <= 3'h1;
            r.xpol_step  <= 3'h1;
        end else begin
            r <= r_nxt;
        end
    end

    assign O_RX_I_DAC        = r.rx_dac.i_code;
    assign O_RX_Q_DAC        = r.rx_dac.q_code;
    assign O_XPOL_I_DAC      = r.xpol_dac.i_code;
    assign O_XPOL_Q_DAC      = r.xpol_dac.q_code;
    assign O_RX_FULL_SCALE   = r.rx.full_scale;
    assign O_XPOL_FULL_SCALE = r.xpol.full_scale;
    assign O_RX_STEP_MULT    = r.rx_step;
    assign O_XPOL_STEP_MULT  = r.xpol_step;
    assign O_RX_AUTOCAL_GO   = r.rx.go;
    assign O_XPOL_AUTOCAL_GO = r.xpol.go;

endmodule

// ### hw/dcoff_params.svh
// Register map, field positions, reset values and counts of the dc-offset calibration block
`ifndef DCOFF_PARAMS_SVH
`define DCOFF_PARAMS_SVH

`define SER_WORD_BITS      32
`define SER_ADDR_HI        2
`define SER_ADDR_LO        0
`define REG_CAL_CONTROL    3'h5
`define REG_CAL_VALUES     3'h7

`define RX_GO_BIT          5
`define RX_FS_HI           13
`define RX_FS_LO           12
`define RX_RATIO_HI        16
`define RX_RATIO_LO        14
`define XPOL_GO_BIT        18
`define XPOL_FS_HI         26
`define XPOL_FS_LO         25
`define XPOL_RATIO_HI      29
`define XPOL_RATIO_LO      27

`define I_CODE_HI          12
`define I_CODE_LO          5
`define Q_CODE_HI          20
`define Q_CODE_LO          13
`define SRC_SEL_BIT        21

`define HALF_SCALE         8'h80
`define SRC_SEL_RESET      1'b1
`define RATIO_RESET        3'h0
`define FS_RESET           2'h0
`define CAL_CYCLES         4'hd
`define SAR_STEPS          4'h8
`define CODE_MAX           8'hff
`define CODE_MIN           8'h00
`define DIV_ONE            8'h01

`endif

// ### hw/dcoff_pkg.sv
// Types of the dc-offset calibration block
package dcoff_pkg;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_RUN  = 2'b10
    } cal_state_t;

    typedef struct packed {
        logic [7:0] i_code;
        logic [7:0] q_code;
    } corr_pair_t;

    typedef struct packed {
        cal_state_t state;
        logic [7:0] div_cnt;
        logic [3:0] step;
        corr_pair_t code;
        logic       busy;
        logic       done;
    } cal_regs_t;

    typedef struct packed {
        logic [2:0] ratio;
        logic [1:0] full_scale;
        logic       go;
    } chain_ctrl_t;

    typedef struct packed {
        logic [31:0] shift;
        logic        spi_clk_d;
        logic        spi_le_d;
        chain_ctrl_t rx;
        chain_ctrl_t xpol;
        logic        src_sel;
        corr_pair_t  manual;
        corr_pair_t  rx_dac;
        corr_pair_t  xpol_dac;
        logic [2:0]  rx_step;
        logic [2:0]  xpol_step;
    } top_regs_t;

endpackage

// ### hw/dcoff_cal_engine.sv
// Thirteen-step automatic calibration engine for one baseband I/Q chain
`timescale 1ns/10ps
`include "dcoff_params.svh"

module dcoff_cal_engine (
    input  wire logic                 i_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_start,
    input  wire logic [2:0]           i_ratio,
    input  wire logic                 i_i_pos,
    input  wire logic                 i_q_pos,
    output logic                      o_busy,
    output logic                      o_done,
    output dcoff_pkg::corr_pair_t     o_code
);

    dcoff_pkg::cal_regs_t r;
    dcoff_pkg::cal_regs_t r_nxt;
    logic [7:0]           div_last;
    logic                 tick;
    logic [2:0]           bit_idx;

    // Divide by two to the power of the ratio code
    assign div_last = (`DIV_ONE << i_ratio) - `DIV_ONE;
    assign tick     = (r.div_cnt == div_last);
    assign bit_idx  = 3'(4'h7 - r.step);

    function automatic logic [7:0] sar_step(input logic [7:0] c, input logic [2:0] b, input logic pos);
        logic [7:0] v;
        v = c;
        v[b] = pos;
        if (b != 3'h0) begin
            v[b - 3'h1] = 1'b1;
        end
        return v;
    endfunction

    function automatic logic [7:0] fine_step(input logic [7:0] c, input logic pos);
        logic [7:0] v;
        v = c;
        if (pos && c != `CODE_MAX) begin
            v = c + 8'h01;
        end else if (!pos && c != `CODE_MIN) begin
            v = c - 8'h01;
        end
        return v;
    endfunction

    always_comb begin
        r_nxt = r;
        r_nxt.done = 1'b0;
        case (r.state)
            dcoff_pkg::CAL_IDLE: begin
                if (i_start) begin
                    r_nxt.state   = dcoff_pkg::CAL_RUN;
                    r_nxt.busy    = 1'b1;
                    r_nxt.div_cnt = 8'h00;
                    r_nxt.step    = 4'h0;
                    r_nxt.code    = '{i_code: `HALF_SCALE, q_code: `HALF_SCALE};
                end
            end
            dcoff_pkg::CAL_RUN: begin
                r_nxt.div_cnt = tick ? 8'h00 : r.div_cnt + 8'h01;
                if (tick) begin
                    // Sense the offset sign and refine the code on each divider tick
                    if (r.step < `SAR_STEPS) begin
                        r_nxt.code.i_code = sar_step(r.code.i_code, bit_idx, i_i_pos);
                        r_nxt.code.q_code = sar_step(r.code.q_code, bit_idx, i_q_pos);
                    end else begin
                        r_nxt.code.i_code = fine_step(r.code.i_code, i_i_pos);
                        r_nxt.code.q_code = fine_step(r.code.q_code, i_q_pos);
                    end
                    r_nxt.step = r.step + 4'h1;
                    if (r.step == `CAL_CYCLES - 4'h1) begin
                        r_nxt.state = dcoff_pkg::CAL_IDLE;
                        r_nxt.busy  = 1'b0;
                        r_nxt.done  = 1'b1;
                    end
                end
            end
            default: begin
                r_nxt.state = dcoff_pkg::CAL_IDLE;
                r_nxt.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            r.state   <= dcoff_pkg::CAL_IDLE;
            r.div_cnt <= 8'h00;
            r.step    <= 4'h0;
            r.code    <= '{i_code: `HALF_SCALE, q_code: `HALF_SCALE};
            r.busy    <= 1'b0;
            r.done    <= 1'b0;
        end else begin
            r <= r_nxt;
        end
    end

    assign o_busy = r.busy;
    assign o_done = r.done;
    assign o_code = r.code;

endmodule

// ### verif/dcoff_host_model.sv
// Host model driving the serial programming port of the calibration block
`timescale 1ns/10ps
module dcoff_host_model (
    input  wire logic i_clk,
    output logic      o_spi_clk,
    output logic      o_spi_data,
    output logic      o_spi_le
);
    initial begin
        o_spi_clk  = 1'b0;
        o_spi_data = 1'b0;
        o_spi_le   = 1'b0;
    end
    // Word goes out LSB first, clock high two core cycles and low three per bit, clock idle low
    task automatic send(input logic [31:0] w);
        for (int b = 0; b < 32; b++) begin
            @(posedge i_clk) o_spi_data <= w[b];
            repeat (2) @(posedge i_clk);
            o_spi_clk <= 1'b1;
            repeat (2) @(posedge i_clk);
            o_spi_clk <= 1'b0;
        end
        @(posedge i_clk) o_spi_le <= 1'b1;
        o_spi_data <= ~w[31];
        repeat (2) @(posedge i_clk);
        o_spi_le <= 1'b0;
    endtask
endmodule

// ### verif/dcoff_cal_top_assertions.sv
// Concurrent checks on the ports of the calibration top
`timescale 1ns/10ps
module dcoff_cal_top_assertions (
    input wire logic       I_CORE_CLK,
    input wire logic       I_RSTN,
    input wire logic       I_SPI_LE,
    input wire logic [7:0] O_RX_I_DAC,
    input wire logic [7:0] O_XPOL_I_DAC,
    input wire logic [1:0] O_RX_FULL_SCALE,
    input wire logic [1:0] O_XPOL_FULL_SCALE,
    input wire logic [2:0] O_RX_STEP_MULT,
    input wire logic [2:0] O_XPOL_STEP_MULT,
    input wire logic       O_RX_AUTOCAL_GO,
    input wire logic       O_XPOL_AUTOCAL_GO
);
    logic [10:0] rx_len_r;
    logic [10:0] xp_len_r;
    always_ff @(posedge I_CORE_CLK) begin
        rx_len_r <= (I_RSTN && O_RX_AUTOCAL_GO) ? rx_len_r + 11'h1 : 11'h0;
        xp_len_r <= (I_RSTN && O_XPOL_AUTOCAL_GO) ? xp_len_r + 11'h1 : 11'h0;
    end
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RSTN);
    a_rst_half_scale: assert property (disable iff (1'b0) !I_RSTN |=> O_RX_I_DAC == 8'h80 &&
        O_XPOL_I_DAC == 8'h80 && !O_RX_AUTOCAL_GO && !O_XPOL_AUTOCAL_GO) else $error("Reset values wrong");
    a_rx_step_scale: assert property (O_RX_STEP_MULT == $past(O_RX_FULL_SCALE) + 3'h1)
        else $error("Rx step does not follow range");
    a_xp_step_scale: assert property (O_XPOL_STEP_MULT == $past(O_XPOL_FULL_SCALE) + 3'h1)
        else $error("Xpol step does not follow range");
    a_rx_go_start: assert property ($rose(O_RX_AUTOCAL_GO) |-> $past(I_SPI_LE))
        else $error("Rx go rose without a write");
    a_xp_go_start: assert property ($rose(O_XPOL_AUTOCAL_GO) |-> $past(I_SPI_LE))
        else $error("Xpol go rose without a write");
    a_rx_range_write: assert property ($changed(O_RX_FULL_SCALE) |-> $past(I_SPI_LE))
        else $error("Rx range changed without a write");
    a_rx_code_held: assert property ($changed(O_RX_I_DAC) |-> $past(O_RX_AUTOCAL_GO) ||
        $past(O_RX_AUTOCAL_GO, 2) || $past(I_SPI_LE, 2) || $past(I_SPI_LE, 4)) else $error("Rx code drifted");
    a_xp_code_held: assert property ($changed(O_XPOL_I_DAC) |-> $past(O_XPOL_AUTOCAL_GO) ||
        $past(O_XPOL_AUTOCAL_GO, 2) || $past(I_SPI_LE, 2) || $past(I_SPI_LE, 4)) else $error("Xpol code drifted");
    a_rx_cal_len: assert property ($fell(O_RX_AUTOCAL_GO) |-> rx_len_r >= 11'd13)
        else $error("Rx calibration too short");
    a_xp_cal_len: assert property ($fell(O_XPOL_AUTOCAL_GO) |-> xp_len_r >= 11'd13)
        else $error("Xpol calibration too short");
    a_rx_cal_bound: assert property (rx_len_r <= 11'd1670)
        else $error("Rx calibration never ends");
endmodule

bind dcoff_cal_top dcoff_cal_top_assertions i_dcoff_cal_top_assertions (.I_CORE_CLK(I_CORE_CLK),
    .I_RSTN(I_RSTN), .I_SPI_LE(I_SPI_LE), .O_RX_I_DAC(O_RX_I_DAC), .O_XPOL_I_DAC(O_XPOL_I_DAC),
    .O_RX_FULL_SCALE(O_RX_FULL_SCALE), .O_XPOL_FULL_SCALE(O_XPOL_FULL_SCALE), .O_RX_STEP_MULT(O_RX_STEP_MULT),
    .O_XPOL_STEP_MULT(O_XPOL_STEP_MULT), .O_RX_AUTOCAL_GO(O_RX_AUTOCAL_GO), .O_XPOL_AUTOCAL_GO(O_XPOL_AUTOCAL_GO));

// ### verif/tb_dcoff_cal_top.sv
// Self-checking bench for the calibration top
`timescale 1ns/10ps
module tb_dcoff_cal_top;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [3:0] pos = 4'h0;
    logic       sck, sda, sle, rgo, xgo;
    logic [7:0] dac [4];
    logic [1:0] rfs, xfs;
    logic [2:0] rsm, xsm;
    int         errors = 0, n_checks = 0, sel = 1, rlen, xlen;
    int         tgt [4] = '{256, 256, 256, 256}, eng [4] = '{128, 128, 128, 128}, man [2];
    always #12.5 clk = ~clk;
    // Offset detectors: raise the code while it sits below the target
    always @(posedge clk)
        for (int i = 0; i < 4; i++) pos[i] <= dac[i] < tgt[i];
    always @(posedge clk) begin
        rlen += rgo;
        xlen += xgo;
    end
    dcoff_host_model i_dcoff_host_model (.i_clk(clk), .o_spi_clk(sck), .o_spi_data(sda), .o_spi_le(sle));
    dcoff_cal_top i_dcoff_cal_top (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_SPI_CLK(sck), .I_SPI_DATA(sda),
        .I_SPI_LE(sle), .I_RX_I_OFS_POS(pos[0]), .I_RX_Q_OFS_POS(pos[1]), .I_XPOL_I_OFS_POS(pos[2]),
        .I_XPOL_Q_OFS_POS(pos[3]), .O_RX_I_DAC(dac[0]), .O_RX_Q_DAC(dac[1]), .O_XPOL_I_DAC(dac[2]),
        .O_XPOL_Q_DAC(dac[3]), .O_RX_FULL_SCALE(rfs), .O_XPOL_FULL_SCALE(xfs), .O_RX_STEP_MULT(rsm),
        .O_XPOL_STEP_MULT(xsm), .O_RX_AUTOCAL_GO(rgo), .O_XPOL_AUTOCAL_GO(xgo));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Reference search: eight approximation steps, then five single steps
    function automatic int cal(input int t);
        int c;
        c = 128;
        for (int b = 7; b >= 0; b--) begin
            if (!(c < t)) c -= 1 << b;
            if (b > 0) c += 1 << (b - 1);
        end
        for (int k = 0; k < 5; k++) c = (c < t) ? ((c < 255) ? c + 1 : c) : ((c > 0) ? c - 1 : c);
        return c;
    endfunction
    task automatic check_dacs;
        for (int i = 0; i < 4; i++) check("dac", dac[i], sel ? eng[i] : man[i % 2]);
    endtask
    task automatic ctrl(input int rr, rf, rg, xr, xf, xg);
        i_dcoff_host_model.send(32'(xr << 27 | xf << 25 | xg << 18 | rr << 14 | rf << 12 | rg << 5 | 5));
        repeat (4) @(posedge clk);
        check("range", {rfs, xfs}, 32'(rf << 2 | xf));
        check("step", {rsm, xsm}, 32'((rf + 1) << 3 | (xf + 1)));
        check("go", {rgo, xgo}, 32'(rg << 1 | xg));
    endtask
    task automatic vals(input int a, s, q, i);
        i_dcoff_host_model.send(32'(s << 21 | q << 13 | i << 5 | a));
        if (a == 7) begin
            sel = s;
            man = '{i, q};
        end
        repeat (4) @(posedge clk);
        check_dacs;
    endtask
    // Receive LO taken as on throughout; no port carries it
    task automatic calib(input int rr, xr);
        int r;
        for (int i = 0; i < 4; i++) begin
            r = (i < 2) ? rr : xr;
            tgt[i] = (r < 2) ? ($urandom % 2) * 256 : $urandom % 256;
            eng[i] = cal(tgt[i]);
        end
        rlen = 0;
        xlen = 0;
        ctrl(rr, rr % 4, 1, xr, 3 - rr % 4, 1);
        for (int n = 0; n < 4000 && (rgo || xgo); n++) @(posedge clk);
        repeat (3) @(posedge clk);
        check("rx_len", rlen >= 13 << rr && rlen <= (13 << rr) + 2, 1);
        check("xpol_len", xlen >= 13 << xr && xlen <= (13 << xr) + 2, 1);
        check_dacs;
    endtask
    initial begin
        void'($urandom(86));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check("idle", {rfs, xfs, rsm, xsm, rgo, xgo}, {20'h0, 4'h0, 3'h1, 3'h1, 2'h0});
        check_dacs;
        // Every ratio on both chains, slower ones giving the detectors more cycles to settle per step
        for (int k = 0; k < 8; k++) calib(k, 7 - k);
        ctrl(1, 2, 0, 4, 1, 0);
        check_dacs;
        vals(7, 0, $urandom % 256, $urandom % 256);
        vals(6, 1, 8'h11, 8'h22);
        vals(7, 1, $urandom % 256, $urandom % 256);
        calib(3, 2);
        end_of_test;
    end
    initial begin
        #1000000;
        errors++;
        end_of_test;
    end
endmodule
